// >>> core/rlo_pkg.sv
// Constants and types for the relative-offset and dB reference control block.
package rlo_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int RLO_CLK_NS = 10;
  localparam int RLO_TICK_NS = 1_000_000;
  localparam int RLO_TICK_CYC = RLO_TICK_NS / RLO_CLK_NS;
  localparam int RLO_MS_PER_S = 1000;
  localparam int RLO_FIRST_S = 3;
  localparam int RLO_STEP_S = 1;
  localparam logic [11:0] RLO_FIRST_MS = 12'(RLO_FIRST_S * RLO_MS_PER_S);
  localparam logic [11:0] RLO_STEP_MS = 12'(RLO_STEP_S * RLO_MS_PER_S);

  // ****************************************
  // Readings and impedance table
  // ****************************************
  localparam int RLO_CW = 18;
  localparam logic signed [RLO_CW-1:0] RLO_LIMIT = 18'sh04e1f;
  localparam int RLO_ZNUM = 16;
  localparam logic [3:0] RLO_ZDEF_RESET = 4'hb;
  localparam logic [15:0] RLO_ZTAB [RLO_ZNUM] = '{
    16'h0008, 16'h0032, 16'h004b, 16'h005d, 16'h006e, 16'h007c, 16'h007d, 16'h0087,
    16'h0096, 16'h00fa, 16'h012c, 16'h0258, 16'h0320, 16'h0384, 16'h03e8, 16'h04b0};

  // ****************************************
  // Front-panel pin positions and range keys
  // ****************************************
  localparam int RLO_NPIN = 12;
  localparam int RLO_NRANGE = 6;
  localparam int RLO_P_PWR = 11;
  localparam int RLO_P_REL = 10;
  localparam int RLO_P_AC = 9;
  localparam int RLO_P_VOLT = 8;
  localparam int RLO_P_AMP = 7;
  localparam int RLO_P_OHM = 6;
  localparam logic [5:0] RLO_REFZ_KEY = 6'h20;
  localparam logic [5:0] RLO_COND_MS_KEYS = 6'h18;
  localparam logic [5:0] RLO_COND_NS_KEYS = 6'h30;
  localparam logic [2:0] RLO_RNG_COND_MS = 3'h4;
  localparam logic [2:0] RLO_RNG_COND_NS = 3'h0;

  // ****************************************
  // APB register map
  // ****************************************
  localparam int RLO_AW = 8;
  localparam logic [7:0] RLO_ZDEF_OFS = 8'h00;
  localparam logic [7:0] RLO_ZSEL_OFS = 8'h04;
  localparam logic [7:0] RLO_STAT_OFS = 8'h08;
  localparam logic [7:0] RLO_DISP_OFS = 8'h0c;
  localparam logic [7:0] RLO_REF_OFS = 8'h10;
  localparam int RLO_ST_RANGE = 3;
  localparam int RLO_ST_REL = 6;
  localparam int RLO_ST_VALID = 7;
  localparam int RLO_ST_OVR = 8;
  localparam int RLO_ST_SEQ = 9;
  localparam int RLO_ST_PWR = 10;

  typedef enum logic [2:0] {
    RLO_V_DC = 3'h0, RLO_V_AC = 3'h1, RLO_I_DC = 3'h2, RLO_I_AC = 3'h3,
    RLO_DB_DC = 3'h4, RLO_DB_AC = 3'h5, RLO_OHM = 3'h6, RLO_COND = 3'h7
  } rlo_func_type;

  typedef enum logic [2:0] {
    RLO_ZS_IDLE = 3'b001, RLO_ZS_FIRST = 3'b010, RLO_ZS_STEP = 3'b100
  } rlo_zseq_type;

endpackage

// >>> core/rlo_scale.sv
// Decade rescaler that moves a stored reference to the present range.
`timescale 1ns/10ps
module rlo_scale
  import rlo_pkg::*;
#(
  parameter int W = RLO_CW
) (
  input logic signed [W-1:0] ref_in,
  input logic [2:0] ref_range,
  input logic [2:0] cur_range,
  output logic signed [W-1:0] ref_out
);

  localparam int XW = W + 24;
  localparam logic signed [XW-1:0] XMAX = XW'((64'sd1 <<< (W - 1)) - 1);

  logic signed [XW-1:0] acc;

  // A higher range index is a coarser range, so the count shrinks tenfold per step.
  // The result saturates, because a large reference moved down many decades cannot fit.
  always_comb begin
    acc = XW'(ref_in);
    for (int i = 0; i < 7; i++) begin
      if (cur_range > ref_range && i < int'(cur_range - ref_range)) begin
        acc = acc / 10;
      end else if (cur_range < ref_range && i < int'(ref_range - cur_range)) begin
        acc = acc * 10;
      end
    end
    if (acc > XMAX) begin
      ref_out = W'(XMAX);
    end else if (acc < -XMAX) begin
      ref_out = W'(-XMAX);
    end else begin
      ref_out = W'(acc);
    end
  end

endmodule // rlo_scale

// >>> core/rlo_core.sv
// Relative reference and dB reference impedance control with an APB register slave.
`timescale 1ns/10ps
module rlo_core
  import rlo_pkg::*;
#(
  parameter int TICK_CYCLES = RLO_TICK_CYC,
  parameter int CW = RLO_CW
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [RLO_AW-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic pwr_sw,
  input logic rel_sw,
  input logic ac_sw,
  input logic volt_key,
  input logic amp_key,
  input logic ohm_key,
  input logic [RLO_NRANGE-1:0] range_key,
  input logic conv_valid,
  input logic signed [CW-1:0] conv_count,
  output logic signed [CW-1:0] disp_value,
  output logic disp_overrange,
  output logic relative_annunciator,
  output logic db_annunciator,
  output logic [15:0] zref_ohms,
  output logic [3:0] zref_index
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [RLO_NPIN-1:0] pin_raw;
  logic [RLO_NPIN-1:0] pin_meta_q;
  logic [RLO_NPIN-1:0] pin_sync_q;
  logic [RLO_NPIN-1:0] pin_prev_q;

  assign pin_raw = {pwr_sw, rel_sw, ac_sw, volt_key, amp_key, ohm_key, range_key};

  // Panel switches bounce and are asynchronous; each bit gets two stages.
  genvar g;
  generate
    for (g = 0; g < RLO_NPIN; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_meta_q[g] <= 1'b0;
          pin_sync_q[g] <= 1'b0;
        end else begin
          pin_meta_q[g] <= pin_raw[g];
          pin_sync_q[g] <= pin_meta_q[g];
        end
      end
    end
  endgenerate

  // Previous synchronised level, for edge detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_sync_q;
    end
  end

  logic pwr_on;
  logic pwr_rise;
  logic rel_on;
  logic rel_rise;
  logic rel_fall;
  logic [RLO_NRANGE-1:0] rk;
  logic [RLO_NRANGE-1:0] rk_rise;

  assign pwr_on = pin_sync_q[RLO_P_PWR];
  assign pwr_rise = pwr_on & ~pin_prev_q[RLO_P_PWR];
  assign rel_on = pin_sync_q[RLO_P_REL];
  assign rel_rise = rel_on & ~pin_prev_q[RLO_P_REL];
  assign rel_fall = ~rel_on & pin_prev_q[RLO_P_REL];
  assign rk = pin_sync_q[RLO_NRANGE-1:0];
  assign rk_rise = rk & ~pin_prev_q[RLO_NRANGE-1:0];

  // ****************************************
  // Function and range decode
  // ****************************************
  rlo_func_type func_q;
  rlo_func_type func_d;
  logic [2:0] range_q;
  logic [2:0] range_d;
  logic is_db;
  logic [RLO_NRANGE-1:0] rk_eff;

  assign is_db = (func_q == RLO_DB_DC) || (func_q == RLO_DB_AC);

  // With no function key down the last function holds, like a released interlock.
  always_comb begin
    func_d = func_q;
    if (pin_sync_q[RLO_P_VOLT] && pin_sync_q[RLO_P_AMP]) begin
      func_d = pin_sync_q[RLO_P_AC] ? RLO_DB_AC : RLO_DB_DC;
    end else if (pin_sync_q[RLO_P_VOLT]) begin
      func_d = pin_sync_q[RLO_P_AC] ? RLO_V_AC : RLO_V_DC;
    end else if (pin_sync_q[RLO_P_AMP]) begin
      func_d = pin_sync_q[RLO_P_AC] ? RLO_I_AC : RLO_I_DC;
    end else if (pin_sync_q[RLO_P_OHM] && (rk == RLO_COND_MS_KEYS || rk == RLO_COND_NS_KEYS)) begin
      func_d = RLO_COND;
    end else if (pin_sync_q[RLO_P_OHM]) begin
      func_d = RLO_OHM;
    end
  end

  // In dB the rightmost key is the impedance key, not a range.
  assign rk_eff = is_db ? (rk & ~RLO_REFZ_KEY) : rk;

  // The lowest pressed key wins; conductance pairs map to their own decades.
  always_comb begin
    range_d = range_q;
    if (func_d == RLO_COND) begin
      range_d = (rk == RLO_COND_MS_KEYS) ? RLO_RNG_COND_MS : RLO_RNG_COND_NS;
    end else begin
      for (int i = RLO_NRANGE - 1; i >= 0; i--) begin
        if (rk_eff[i]) begin
          range_d = 3'(i);
        end
      end
    end
  end

  // Function and range registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= RLO_V_DC;
      range_q <= 3'h0;
    end else begin
      func_q <= func_d;
      range_q <= range_d;
    end
  end

  // ****************************************
  // Relative reference store
  // ****************************************
  logic signed [CW-1:0] last_raw_q;
  logic [2:0] last_range_q;
  logic ref_valid_q;
  logic signed [CW-1:0] ref_val_q;
  rlo_func_type ref_func_q;
  logic [2:0] ref_range_q;
  logic rel_active;
  logic signed [CW-1:0] ref_scaled;

  // The latest reading and the range it was taken on are what a capture stores.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_raw_q <= '0;
      last_range_q <= 3'h0;
    end else if (conv_valid && pwr_on) begin
      last_raw_q <= conv_count;
      last_range_q <= range_q;
    end
  end

  // One slot holds the reference, tagged with its function; a new capture replaces it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_valid_q <= 1'b0;
      ref_val_q <= '0;
      ref_func_q <= RLO_V_DC;
      ref_range_q <= 3'h0;
    end else if (!pwr_on || rel_fall) begin
      ref_valid_q <= 1'b0;
    end else if (rel_rise) begin
      ref_valid_q <= 1'b1;
      ref_val_q <= last_raw_q;
      ref_func_q <= func_q;
      ref_range_q <= last_range_q;
    end
  end

  // The reference applies only in its own function, so leaving hides it and
  // returning brings it back without touching the store.
  assign rel_active = pwr_on & rel_on & ref_valid_q & (ref_func_q == func_q);

  rlo_scale #(
    .W(CW)
  ) u_scale (
    .ref_in(ref_val_q),
    .ref_range(ref_range_q),
    .cur_range(range_q),
    .ref_out(ref_scaled)
  );

  // ****************************************
  // Display path
  // ****************************************
  logic signed [CW:0] diff;
  logic raw_over;
  logic diff_over;
  logic signed [CW-1:0] diff_clip;
  logic signed [CW-1:0] disp_q;
  logic ovr_q;
  logic rel_ann_q;
  logic db_ann_q;

  assign diff = {conv_count[CW-1], conv_count} - {ref_scaled[CW-1], ref_scaled};
  assign raw_over = (conv_count > RLO_LIMIT) || (conv_count < -RLO_LIMIT);
  assign diff_over = (diff > (CW+1)'(RLO_LIMIT)) || (diff < -((CW+1)'(RLO_LIMIT)));
  assign diff_clip = diff_over ? (diff[CW] ? -RLO_LIMIT : RLO_LIMIT) : diff[CW-1:0];

  logic zs_busy;
  logic [3:0] seq_idx_q;

  // The converter span stays in force whatever the reference, so a raw reading
  // past the limit flags overrange even when the difference would fit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_q <= '0;
      ovr_q <= 1'b0;
    end else if (!pwr_on) begin
      disp_q <= '0;
      ovr_q <= 1'b0;
    end else if (zs_busy) begin
      disp_q <= CW'(RLO_ZTAB[seq_idx_q]);
      ovr_q <= 1'b0;
    end else if (rel_rise) begin
      disp_q <= '0;
      ovr_q <= 1'b0;
    end else if (conv_valid) begin
      disp_q <= rel_active ? diff_clip : conv_count;
      ovr_q <= raw_over | (rel_active & diff_over);
    end
  end

  // Annunciators follow the decoded state one cycle later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_ann_q <= 1'b0;
      db_ann_q <= 1'b0;
    end else begin
      rel_ann_q <= rel_active;
      db_ann_q <= pwr_on & is_db;
    end
  end

  // ****************************************
  // Reference impedance sequencer
  // ****************************************
  rlo_zseq_type zs_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick;
  logic [11:0] ms_q;
  logic expire;
  logic refz_rise;
  logic other_rise;
  logic [3:0] zsel_q;
  logic [3:0] zdef_q;
  logic apb_wr;

  assign zs_busy = (zs_q != RLO_ZS_IDLE);
  assign refz_rise = pwr_on & is_db & |(rk_rise & RLO_REFZ_KEY);
  assign other_rise = pwr_on & is_db & |(rk_rise & ~RLO_REFZ_KEY);
  assign tick = zs_busy && (tick_cnt_q == TICK_LAST);
  assign expire = tick && (((zs_q == RLO_ZS_FIRST) && (ms_q == RLO_FIRST_MS - 12'h001)) ||
                           ((zs_q == RLO_ZS_STEP) && (ms_q == RLO_STEP_MS - 12'h001)));

  // Millisecond enable; it restarts with each impedance key press so the first interval is whole.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
    end else if (!zs_busy || refz_rise || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Milliseconds into the present interval.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= 12'h000;
    end else if (refz_rise || expire || !zs_busy) begin
      ms_q <= 12'h000;
    end else if (tick) begin
      ms_q <= ms_q + 12'h001;
    end
  end

  // Leaving dB or losing power abandons the sequence without changing the selection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zs_q <= RLO_ZS_IDLE;
    end else if (!pwr_on || !is_db) begin
      zs_q <= RLO_ZS_IDLE;
    end else begin
      case (zs_q)
        RLO_ZS_IDLE: begin
          if (refz_rise) begin
            zs_q <= RLO_ZS_FIRST;
          end
        end
        RLO_ZS_FIRST: begin
          if (other_rise) begin
            zs_q <= RLO_ZS_IDLE;
          end else if (expire) begin
            zs_q <= RLO_ZS_STEP;
          end
        end
        RLO_ZS_STEP: begin
          if (other_rise) begin
            zs_q <= RLO_ZS_IDLE;
          end else if (refz_rise) begin
            zs_q <= RLO_ZS_FIRST;
          end
        end
        default: begin
          zs_q <= RLO_ZS_IDLE;
        end
      endcase
    end
  end

  // The shown entry starts at the selection, then walks the table and wraps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_idx_q <= RLO_ZDEF_RESET;
    end else if (refz_rise) begin
      seq_idx_q <= zsel_q;
    end else if (expire) begin
      seq_idx_q <= seq_idx_q + 4'h1;
    end
  end

  // Selection: default at power-up, shown entry on a range key, or software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zsel_q <= RLO_ZDEF_RESET;
    end else if (pwr_rise) begin
      zsel_q <= zdef_q;
    end else if (zs_busy && other_rise) begin
      zsel_q <= seq_idx_q;
    end else if (apb_wr && paddr == RLO_ZSEL_OFS) begin
      zsel_q <= pwdata[3:0];
    end
  end

  // The impedance handed to the dBm conversion comes from the fixed table.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zref_ohms <= RLO_ZTAB[RLO_ZDEF_RESET];
    end else begin
      zref_ohms <= RLO_ZTAB[zsel_q];
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic hit;
  logic [31:0] rd_mux;

  assign apb_wr = psel & penable & pwrite;
  assign hit = (paddr == RLO_ZDEF_OFS) || (paddr == RLO_ZSEL_OFS) ||
               (paddr == RLO_STAT_OFS) || (paddr == RLO_DISP_OFS) || (paddr == RLO_REF_OFS);
  // Zero wait states; an unmapped address errors in the access phase.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Read mux; reserved bits read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      RLO_ZDEF_OFS: rd_mux[3:0] = zdef_q;
      RLO_ZSEL_OFS: rd_mux[3:0] = zsel_q;
      RLO_STAT_OFS: begin
        rd_mux[2:0] = func_q;
        rd_mux[RLO_ST_RANGE +: 3] = range_q;
        rd_mux[RLO_ST_REL] = rel_active;
        rd_mux[RLO_ST_VALID] = ref_valid_q;
        rd_mux[RLO_ST_OVR] = ovr_q;
        rd_mux[RLO_ST_SEQ] = zs_busy;
        rd_mux[RLO_ST_PWR] = pwr_on;
      end
      RLO_DISP_OFS: rd_mux = {{(32 - CW){disp_q[CW-1]}}, disp_q};
      RLO_REF_OFS: rd_mux = {{(32 - CW){ref_scaled[CW-1]}}, ref_scaled};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is sampled in the setup cycle so it comes from a flip-flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // The default survives power switching; only the reset line restores it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zdef_q <= RLO_ZDEF_RESET;
    end else if (apb_wr && paddr == RLO_ZDEF_OFS) begin
      zdef_q <= pwdata[3:0];
    end
  end

  assign disp_value = disp_q;
  assign disp_overrange = ovr_q;
  assign relative_annunciator = rel_ann_q;
  assign db_annunciator = db_ann_q;
  assign zref_index = zsel_q;

endmodule // rlo_core

// >>> test/rlo_sva.sv
// Port-level checker for the relative-offset and dB reference control block.
`timescale 1ns/10ps
module rlo_sva
  import rlo_pkg::*;
#(
  parameter int TICK_CYCLES = RLO_TICK_CYC,
  parameter int CW = RLO_CW
) (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic [RLO_AW-1:0] paddr,
  input logic pslverr,
  input logic pwr_sw,
  input logic rel_sw,
  input logic volt_key,
  input logic amp_key,
  input logic ohm_key,
  input logic conv_valid,
  input logic signed [CW-1:0] conv_count,
  input logic signed [CW-1:0] disp_value,
  input logic disp_overrange,
  input logic relative_annunciator,
  input logic db_annunciator,
  input logic [15:0] zref_ohms,
  input logic [3:0] zref_index
);
  // ****
  // Assertions
  // ****
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The error response belongs to the access phase and to holes in the map.
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  AST_UNMAPPED: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
  // The pins pass a synchroniser, so each relation allows a few clocks of lag.
  AST_REL_CAPTURE: assert property ($rose(rel_sw) ##0
    (pwr_sw && rel_sw && !conv_valid) [*5] |-> disp_value == 0 && relative_annunciator)
    else $error("relative on did not zero and light");
  AST_REL_OFF: assert property (!rel_sw [*6] |=> !relative_annunciator)
    else $error("annunciator lit with relative off");
  AST_PWR_OFF: assert property (!pwr_sw [*6] |=>
    !relative_annunciator && disp_value == 0)
    else $error("display live with power off");
  AST_OVR: assert property (pwr_sw [*4] ##0 (conv_valid && (conv_count > RLO_LIMIT
    || conv_count < -RLO_LIMIT)) |=> disp_overrange)
    else $error("raw reading beyond span not flagged");
  AST_DB_ON: assert property ((pwr_sw && volt_key && amp_key && !ohm_key) [*6]
    |=> db_annunciator)
    else $error("dB not entered with both keys");
  // Both voltage and current keys win over the resistance key, so only that pair means dB.
  AST_DB_OFF: assert property (((volt_key || amp_key || ohm_key)
    && !(volt_key && amp_key)) [*6] |=> !db_annunciator)
    else $error("dB shown outside dB function");
  AST_ZOHM: assert property ($stable(zref_index) |->
    zref_ohms == RLO_ZTAB[zref_index])
    else $error("impedance does not match table entry");

  // ****
  // Covers
  // ****
  COV_CAPTURE: cover property ($rose(relative_annunciator));
  COV_OVR: cover property ($rose(disp_overrange));
  COV_ERR: cover property (pslverr);
endmodule // rlo_sva

bind rlo_core rlo_sva #(.TICK_CYCLES(TICK_CYCLES), .CW(CW)) rlo_sva_i (
  .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .pwr_sw, .rel_sw, .volt_key,
  .amp_key, .ohm_key, .conv_valid, .conv_count, .disp_value, .disp_overrange,
  .relative_annunciator, .db_annunciator, .zref_ohms, .zref_index);

// >>> test/rlo_conv_model.sv
// Converter model that delivers a reading every sixteen clocks.
`timescale 1ns/10ps
module rlo_conv_model
  import rlo_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic signed [RLO_CW-1:0] level,
  output logic conv_valid,
  output logic signed [RLO_CW-1:0] conv_count
);
  logic [3:0] tick_q;

  // Between strobes the count bus carries the inverse, so a design that reads
  // it outside the strobe sees a wrong value instead of a lucky one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 4'h0;
      conv_valid <= 1'b0;
      conv_count <= '0;
    end else begin
      tick_q <= tick_q + 4'h1;
      conv_valid <= (tick_q == 4'hf);
      conv_count <= (tick_q == 4'hf) ? level : ~level;
    end
  end
endmodule // rlo_conv_model

// >>> test/test_relative_offset_and_dbref_control.sv
// Self-checking bench for the relative-offset and dB reference control block.
`timescale 1ns/10ps
module test_relative_offset_and_dbref_control
  import rlo_pkg::*;
;
  localparam int TICKS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pwr_sw = 1'b0, rel_sw = 1'b0, ac_sw = 1'b0;
  logic volt_key = 1'b0, amp_key = 1'b0, ohm_key = 1'b0;
  logic [5:0] range_key = 6'h00;
  logic signed [RLO_CW-1:0] level = 18'sh00000, conv_count, disp_value;
  logic conv_valid, disp_overrange, relative_annunciator, db_annunciator;
  logic [15:0] zref_ohms;
  logic [3:0] zref_index;
  int err_count = 0, checked = 0;
  // Keys {volt, amp, ohm, ac}, range keys, expected function and range code.
  logic [3:0] fk [9] = '{4'h8, 4'h9, 4'h4, 4'h5, 4'hc, 4'hd, 4'h3, 4'h2, 4'h2};
  logic [5:0] fr [9] = '{6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h18, 6'h30};
  logic [2:0] ff [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7};
  logic [2:0] fg [9] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4, 3'h0};

  rlo_core #(.TICK_CYCLES(TICKS)) rlo_core_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pwr_sw, .rel_sw, .ac_sw, .volt_key,
    .amp_key, .ohm_key, .range_key, .conv_valid, .conv_count, .disp_value, .disp_overrange,
    .relative_annunciator, .db_annunciator, .zref_ohms, .zref_index);
  rlo_conv_model rlo_conv_model_i (.pclk, .presetn, .level, .conv_valid, .conv_count);

  // ****
  // Tasks
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk(32'h0, 32'h1, "pready timeout");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****
  // Clock, watchdog and tests
  // ****
  initial begin
    forever #5 pclk = ~pclk;
  end

  // The tests take about 26000 clocks; a hang is cut off well beyond that.
  initial begin
    wt(80000);
    err_count++;
    give_verdict();
  end

  initial begin
    wt(10);
    presetn <= 1'b1;
    apb(1'b0, RLO_ZDEF_OFS, 32'h0);
    chk(rd, 32'hb, "zdef reset");
    chk(32'(zref_ohms), 32'h258, "ohms reset");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1, "unmapped");
    apb(1'b1, RLO_ZDEF_OFS, 32'hc);
    apb(1'b0, RLO_ZDEF_OFS, 32'h0);
    chk(rd, 32'hc, "zdef write");
    pwr_sw <= 1'b1;
    wt(20);
    chk(32'(zref_index), 32'hc, "power-up index");
    $display("test registers done");
    // Relative capture, subtraction, decade rescale and span limit.
    volt_key <= 1'b1;
    range_key <= 6'h02;
    level <= 18'sh003e8;
    wt(40);
    chk(32'(disp_value), 32'h3e8, "plain reading");
    rel_sw <= 1'b1;
    wt(40);
    chk(32'(disp_value), 32'h0, "zeroed");
    chk(32'(relative_annunciator), 32'h1, "rel lit");
    level <= 18'sh005dc;
    wt(40);
    chk(32'(disp_value), 32'h1f4, "difference");
    range_key <= 6'h04;
    wt(40);
    chk(32'(disp_value), 32'h578, "rescaled diff");
    apb(1'b0, RLO_REF_OFS, 32'h0);
    chk(rd, 32'h64, "rescaled ref");
    level <= 18'sh04e20;
    wt(40);
    chk(32'(disp_overrange), 32'h1, "raw over span");
    level <= 18'sh04e1f;
    wt(40);
    chk(32'(disp_overrange), 32'h0, "raw at span");
    $display("test relative done");
    // The reference follows its function; a newer capture wins.
    level <= 18'sh003e8;
    volt_key <= 1'b0;
    amp_key <= 1'b1;
    wt(40);
    chk(32'(relative_annunciator), 32'h0, "rel off in new func");
    apb(1'b0, RLO_STAT_OFS, 32'h0);
    chk(32'(rd[7]), 32'h1, "ref kept");
    volt_key <= 1'b1;
    amp_key <= 1'b0;
    wt(40);
    chk(32'(relative_annunciator), 32'h1, "rel restored");
    chk(32'(disp_value), 32'h384, "ref reapplied");
    volt_key <= 1'b0;
    amp_key <= 1'b1;
    rel_sw <= 1'b0;
    wt(20);
    rel_sw <= 1'b1;
    wt(40);
    volt_key <= 1'b1;
    amp_key <= 1'b0;
    wt(40);
    chk(32'(relative_annunciator), 32'h0, "replaced ref");
    rel_sw <= 1'b0;
    wt(20);
    apb(1'b0, RLO_STAT_OFS, 32'h0);
    chk(32'(rd[7:6]), 32'h0, "ref discarded");
    $display("test function change done");
    // Every function accepts the relative mode.
    for (int i = 0; i < 9; i++) begin
      {volt_key, amp_key, ohm_key, ac_sw} <= fk[i];
      range_key <= fr[i];
      wt(10);
      rel_sw <= 1'b1;
      wt(40);
      apb(1'b0, RLO_STAT_OFS, 32'h0);
      chk(32'(rd[5:0]), 32'({fg[i], ff[i]}), "func and range");
      chk(32'(relative_annunciator), 32'h1, "rel in func");
      chk(32'(db_annunciator), 32'(ff[i] == 3'h4 || ff[i] == 3'h5), "db");
      rel_sw <= 1'b0;
      wt(10);
    end
    $display("test functions done");
    // Impedance browsing: 3 s on the chosen entry, then one entry a second.
    {volt_key, amp_key, ohm_key, ac_sw} <= 4'hc;
    range_key <= 6'h01;
    wt(10);
    range_key <= 6'h20;
    wt(6000);
    chk(32'(disp_value), 32'(RLO_ZTAB[12]), "first shown");
    apb(1'b0, RLO_STAT_OFS, 32'h0);
    chk(32'(rd[9]), 32'h1, "sequence busy");
    wt(8000);
    chk(32'(disp_value), 32'(RLO_ZTAB[13]), "second shown");
    wt(4000);
    chk(32'(disp_value), 32'(RLO_ZTAB[14]), "third shown");
    range_key <= 6'h01;
    wt(20);
    chk(32'(zref_index), 32'he, "selected");
    chk(32'(zref_ohms), 32'(RLO_ZTAB[14]), "selected ohms");
    apb(1'b0, RLO_STAT_OFS, 32'h0);
    chk(32'(rd[9]), 32'h0, "sequence ended");
    wt(1000);
    range_key <= 6'h20;
    wt(6000);
    chk(32'(disp_value), 32'(RLO_ZTAB[14]), "chosen shown first");
    $display("test impedance done");
    // Power cycling drops the reference for good and reloads the default impedance.
    {volt_key, amp_key, ohm_key, ac_sw} <= 4'h8;
    range_key <= 6'h02;
    wt(10);
    rel_sw <= 1'b1;
    wt(40);
    chk(32'(relative_annunciator), 32'h1, "rel before power off");
    pwr_sw <= 1'b0;
    wt(20);
    chk(32'(disp_value), 32'h0, "display off");
    pwr_sw <= 1'b1;
    wt(40);
    apb(1'b0, RLO_STAT_OFS, 32'h0);
    chk(32'(rd[7:6]), 32'h0, "power ref discarded");
    chk(32'(zref_index), 32'hc, "default reloaded");
    apb(1'b0, RLO_DISP_OFS, 32'h0);
    chk(rd, 32'h3e8, "display register");
    apb(1'b1, RLO_ZSEL_OFS, 32'h3);
    apb(1'b0, RLO_ZSEL_OFS, 32'h0);
    chk(rd, 32'h3, "zsel write");
    chk(32'(zref_ohms), 32'(RLO_ZTAB[3]), "zsel ohms");
    $display("test power done");
    give_verdict();
  end
endmodule // test_relative_offset_and_dbref_control
